// File: src/sschk_pkg.sv
// constants, field layout and types of the substream check block
package sschk_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SUB_W = 20;
  localparam int unsigned ADDR_W = 64;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned NUM_EV = 4;

  // capability values shown in the id register
  localparam logic [5:0] SUPPORTED_SUBINDEX_WIDTH = 6'h14;
  localparam logic [6:0] INPUT_ADDRESS_WIDTH = 7'h30;
  localparam logic STAGE1_IMPL = 1'h1;

  // register byte offsets
  localparam logic [11:0] OFF_ENTRY = 12'h000;
  localparam logic [11:0] OFF_ID = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_MASK = 12'h00c;
  localparam logic [11:0] OFF_RESULT = 12'h010;
  localparam logic [11:0] OFF_ABORTS = 12'h014;

  // entry register fields
  localparam int unsigned ENT_S1_BIT = 0;
  localparam int unsigned ENT_S2_BIT = 1;
  localparam int unsigned ENT_DSS_LSB = 8;
  localparam int unsigned ENT_CNT_LSB = 16;
  // id register fields
  localparam int unsigned ID_SUBW_LSB = 0;
  localparam int unsigned ID_IAW_LSB = 8;
  localparam int unsigned ID_S1_BIT = 16;
  // result register fields
  localparam int unsigned RES_KIND_LSB = 0;
  localparam int unsigned RES_FETCH_BIT = 2;
  localparam int unsigned RES_IDX_LSB = 8;

  // status and mask bit positions
  localparam int unsigned EV_BAD_SUB = 0;
  localparam int unsigned EV_DEF_TERM = 1;
  localparam int unsigned EV_ADDR_SIZE = 2;
  localparam int unsigned EV_ILLEGAL = 3;

  // reset values and the abort count limit
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [NUM_EV-1:0] MASK_RST = 4'h0;
  localparam logic [15:0] ABORTS_RST = 16'h0000;
  localparam logic [15:0] ABORTS_MAX = 16'hffff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    DSS_TERMINATE = 2'b00,
    DSS_BYPASS = 2'b01,
    DSS_SUBZERO = 2'b10,
    DSS_RESERVED = 2'b11
  } sschk_dss_e;

  typedef enum logic [1:0] {
    RES_ABORT = 2'b00,
    RES_DESC = 2'b01,
    RES_PHYS = 2'b10,
    RES_INTER = 2'b11
  } sschk_result_e;
endpackage

// File: src/sschk_decide_if.sv
// decision request and answer between the top and the classifier
`timescale 1ns/100ps
interface sschk_decide_if;
  logic s1_en;
  logic s2_en;
  logic [sschk_pkg::CNT_W-1:0] cnt_log2;
  sschk_pkg::sschk_dss_e dss;
  logic has_sub;
  logic [sschk_pkg::SUB_W-1:0] sub_idx;
  logic [sschk_pkg::ADDR_W-1:0] addr;
  sschk_pkg::sschk_result_e result;
  logic [sschk_pkg::SUB_W-1:0] desc_idx;
  logic fetch_desc;
  logic ev_bad_sub;
  logic ev_def_term;
  logic ev_addr_size;
  modport ask(output s1_en, s2_en, cnt_log2, dss, has_sub, sub_idx, addr,
              input result, desc_idx, fetch_desc, ev_bad_sub, ev_def_term, ev_addr_size);
  modport answer(input s1_en, s2_en, cnt_log2, dss, has_sub, sub_idx, addr,
                 output result, desc_idx, fetch_desc, ev_bad_sub, ev_def_term, ev_addr_size);
endinterface

// File: src/sschk_classify.sv
// combinational substream decision for one transaction
`timescale 1ns/100ps
module sschk_classify (
  sschk_decide_if.answer dif
);
  import sschk_pkg::*;

  logic sub_on;
  logic out_of_span;
  logic size_fault;

  // count field only meaningful with stage 1 on and support present
  assign sub_on = dif.s1_en && (dif.cnt_log2 != CNT_RST) && (SUPPORTED_SUBINDEX_WIDTH != 6'h00);
  // span is 2^count descriptors; index at or past it is outside
  assign out_of_span = (dif.sub_idx >> dif.cnt_log2) != '0;
  assign size_fault = (dif.addr >> INPUT_ADDRESS_WIDTH) != '0;

  always_comb begin
    dif.result = RES_ABORT;
    dif.desc_idx = '0;
    dif.fetch_desc = 1'b0;
    dif.ev_bad_sub = 1'b0;
    dif.ev_def_term = 1'b0;
    dif.ev_addr_size = 1'b0;
    if (dif.has_sub) begin
      if (SUPPORTED_SUBINDEX_WIDTH == 6'h00 || !dif.s1_en || dif.cnt_log2 == CNT_RST) begin
        dif.ev_bad_sub = 1'b1;
      end else if (out_of_span) begin
        dif.ev_bad_sub = 1'b1;
      end else if (dif.dss == DSS_SUBZERO && dif.sub_idx == '0) begin
        dif.ev_def_term = 1'b1;
      end else begin
        dif.result = RES_DESC;
        dif.desc_idx = dif.sub_idx;
        dif.fetch_desc = 1'b1;
      end
    end else if (dif.s1_en && (!sub_on || dif.dss == DSS_SUBZERO)) begin
      // untagged traffic owns index zero
      dif.result = RES_DESC;
      dif.fetch_desc = 1'b1;
    end else if (dif.s1_en && (dif.dss == DSS_TERMINATE || dif.dss == DSS_RESERVED)) begin
      dif.ev_def_term = 1'b1;
    end else if (size_fault) begin
      // bypass path never touches a descriptor
      dif.ev_addr_size = 1'b1;
    end else begin
      dif.result = dif.s2_en ? RES_INTER : RES_PHYS;
    end
  end
endmodule

// File: src/sschk_events.sv
// sticky event flags, mask and interrupt level
`timescale 1ns/100ps
module sschk_events (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [sschk_pkg::NUM_EV-1:0] set_i,
  input wire logic [sschk_pkg::NUM_EV-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [sschk_pkg::NUM_EV-1:0] mask_wdata_i,
  output logic [sschk_pkg::NUM_EV-1:0] status_o,
  output logic [sschk_pkg::NUM_EV-1:0] mask_o,
  output logic irq_o
);
  import sschk_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV; gi++) begin : g_flag
      // set beats a same-cycle write-one clear
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          status_o[gi] <= 1'b0;
        end else if (set_i[gi]) begin
          status_o[gi] <= 1'b1;
        end else if (clr_i[gi]) begin
          status_o[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_o <= MASK_RST;
    end else if (mask_we_i) begin
      mask_o <= mask_wdata_i;
    end
  end

  // registered a cycle behind the flags so the output is a flop
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_o & mask_o);
    end
  end
endmodule

// File: src/sschk_top.sv
// substream check top: bus slave, entry fields and transaction pipeline
`timescale 1ns/100ps

// Summary of operation
// - stage 1 on, count zero: tagged transactions abort with bad substream event
// - count nonzero: tagged index outside span aborts with bad substream event
// - count field ignored while stage 1 is off
// - with substreams on, default select decides untagged handling
// - select 00 terminates untagged traffic, aborts, records default terminate fault
// - select 01 handles untagged traffic as if stage 1 were off
// - bypass: address above input width raises address size fault
// - bypass without fault and stage 2 on: translate as intermediate address
// - bypass fetches no descriptor, so no descriptor related faults
// - select 10 translates untagged traffic with descriptor index zero
// - select 10: tagged index zero terminates with default terminate fault
// - select 11 is reserved and behaves as terminate
// - select ignored when stage 1 off, count zero or support absent
// - count and select read zero, ignore writes without stage 1 or support
// - count is log2 of reachable descriptor number
// - no substream support: tagged transactions abort with bad substream event
module sschk_top (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [sschk_pkg::DATA_W-1:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [sschk_pkg::DATA_W-1:0] hrdata_o,
  input wire logic txn_valid_i,
  input wire logic txn_has_sub_i,
  input wire logic [sschk_pkg::SUB_W-1:0] txn_sub_idx_i,
  input wire logic [sschk_pkg::ADDR_W-1:0] txn_addr_i,
  output logic rsp_valid_o,
  output logic rsp_abort_o,
  output sschk_pkg::sschk_result_e rsp_kind_o,
  output logic [sschk_pkg::SUB_W-1:0] rsp_desc_idx_o,
  output logic rsp_fetch_desc_o,
  output logic irq_o
);
  import sschk_pkg::*;

  // fields hold state only where stage 1 and substreams exist
  localparam logic SUB_FIELDS_LIVE = STAGE1_IMPL && (SUPPORTED_SUBINDEX_WIDTH != 6'h00);

  function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
    hits = (a[11:2] == off[11:2]);
  endfunction

  logic accept;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic rd_pend_q;
  logic [11:0] rd_addr_q;
  logic wr_now;
  logic s1_en_q;
  logic s2_en_q;
  logic [CNT_W-1:0] cnt_log2_q;
  sschk_dss_e dss_q;
  logic [CNT_W-1:0] cnt_wdata;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] ev_clr;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic mask_we;
  logic [15:0] aborts_q;
  sschk_result_e last_kind_q;
  logic last_fetch_q;
  logic [SUB_W-1:0] last_idx_q;
  logic [DATA_W-1:0] rdata_d;
  logic illegal_wr;
  logic wr_entry;
  logic wr_status;
  logic wr_mask;
  logic wr_aborts;
  logic abort_now;

  sschk_decide_if dif ();

  // bus address phase
  assign accept = hsel_i && htrans_i[1] && hready_i;
  assign wr_now = wr_pend_q;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= accept && hwrite_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_addr_q <= '0;
    end else if (accept && hwrite_i) begin
      wr_addr_q <= haddr_i[11:0];
    end
  end

  // one strobe per writable register, live in the write data phase
  assign wr_entry = wr_now && hits(wr_addr_q, OFF_ENTRY);
  assign wr_status = wr_now && hits(wr_addr_q, OFF_STATUS);
  assign wr_mask = wr_now && hits(wr_addr_q, OFF_MASK);
  assign wr_aborts = wr_now && hits(wr_addr_q, OFF_ABORTS);

  // reads take one wait state so a write just before is seen
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= accept && !hwrite_i;
    end
  end

  // address held for the read mux through the wait state
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_addr_q <= '0;
    end else if (accept && !hwrite_i) begin
      rd_addr_q <= haddr_i[11:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b1;
    end else begin
      hreadyout_o <= !(accept && !hwrite_i);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hresp_o <= HRESP_OKAY;
    end else begin
      hresp_o <= HRESP_OKAY;
    end
  end

  // entry configuration
  assign cnt_wdata = hwdata_i[ENT_CNT_LSB +: CNT_W];

  // stage 1 enable cannot stick where stage 1 is absent
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_en_q <= 1'b0;
    end else if (wr_entry) begin
      s1_en_q <= hwdata_i[ENT_S1_BIT] && STAGE1_IMPL;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s2_en_q <= 1'b0;
    end else if (wr_entry) begin
      s2_en_q <= hwdata_i[ENT_S2_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_log2_q <= CNT_RST;
    end else if (wr_entry && SUB_FIELDS_LIVE) begin
      cnt_log2_q <= cnt_wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dss_q <= DSS_TERMINATE;
    end else if (wr_entry && SUB_FIELDS_LIVE) begin
      dss_q <= sschk_dss_e'(hwdata_i[ENT_DSS_LSB +: 2]);
    end
  end

  // a count beyond the supported width is flagged, not corrected
  assign illegal_wr = wr_entry && SUB_FIELDS_LIVE
                      && ({1'b0, cnt_wdata} > SUPPORTED_SUBINDEX_WIDTH);

  // decision request straight from the transaction port
  assign dif.s1_en = s1_en_q;
  assign dif.s2_en = s2_en_q;
  assign dif.cnt_log2 = s1_en_q ? cnt_log2_q : CNT_RST;
  assign dif.dss = dss_q;
  assign dif.has_sub = txn_has_sub_i;
  assign dif.sub_idx = txn_sub_idx_i;
  assign dif.addr = txn_addr_i;

  sschk_classify u_classify (
    .dif(dif)
  );

  // answer one cycle after the request
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
    end else begin
      rsp_valid_o <= txn_valid_i;
    end
  end

  // one abort decision feeds the response and the counter
  assign abort_now = txn_valid_i && (dif.result == RES_ABORT);

  // response fields read zero outside their one-cycle pulse
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_abort_o <= 1'b0;
    end else begin
      rsp_abort_o <= abort_now;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_kind_o <= RES_ABORT;
    end else begin
      rsp_kind_o <= txn_valid_i ? dif.result : RES_ABORT;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_desc_idx_o <= '0;
    end else begin
      rsp_desc_idx_o <= txn_valid_i ? dif.desc_idx : '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_fetch_desc_o <= 1'b0;
    end else begin
      rsp_fetch_desc_o <= txn_valid_i && dif.fetch_desc;
    end
  end

  // last decision kept for software
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_kind_q <= RES_ABORT;
    end else if (txn_valid_i) begin
      last_kind_q <= dif.result;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_fetch_q <= 1'b0;
    end else if (txn_valid_i) begin
      last_fetch_q <= dif.fetch_desc;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_idx_q <= '0;
    end else if (txn_valid_i) begin
      last_idx_q <= dif.desc_idx;
    end
  end

  // abort count saturates; any write clears it, a same-cycle abort then counts as one
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aborts_q <= ABORTS_RST;
    end else if (abort_now) begin
      if (wr_aborts) begin
        aborts_q <= 16'h0001;
      end else if (aborts_q != ABORTS_MAX) begin
        aborts_q <= aborts_q + 16'h0001;
      end
    end else if (wr_aborts) begin
      aborts_q <= ABORTS_RST;
    end
  end

  // events
  always_comb begin
    ev_set = '0;
    ev_set[EV_BAD_SUB] = txn_valid_i && dif.ev_bad_sub;
    ev_set[EV_DEF_TERM] = txn_valid_i && dif.ev_def_term;
    ev_set[EV_ADDR_SIZE] = txn_valid_i && dif.ev_addr_size;
    ev_set[EV_ILLEGAL] = illegal_wr;
  end

  assign ev_clr = wr_status ? hwdata_i[NUM_EV-1:0] : '0;
  assign mask_we = wr_mask;

  sschk_events u_events (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .mask_we_i(mask_we),
    .mask_wdata_i(hwdata_i[NUM_EV-1:0]),
    .status_o(status),
    .mask_o(mask),
    .irq_o(irq_o)
  );

  // read mux
  always_comb begin
    rdata_d = '0;
    if (hits(rd_addr_q, OFF_ENTRY)) begin
      rdata_d[ENT_S1_BIT] = s1_en_q;
      rdata_d[ENT_S2_BIT] = s2_en_q;
      rdata_d[ENT_DSS_LSB +: 2] = dss_q;
      rdata_d[ENT_CNT_LSB +: CNT_W] = cnt_log2_q;
    end else if (hits(rd_addr_q, OFF_ID)) begin
      rdata_d[ID_SUBW_LSB +: 6] = SUPPORTED_SUBINDEX_WIDTH;
      rdata_d[ID_IAW_LSB +: 7] = INPUT_ADDRESS_WIDTH;
      rdata_d[ID_S1_BIT] = STAGE1_IMPL;
    end else if (hits(rd_addr_q, OFF_STATUS)) begin
      rdata_d[NUM_EV-1:0] = status;
    end else if (hits(rd_addr_q, OFF_MASK)) begin
      rdata_d[NUM_EV-1:0] = mask;
    end else if (hits(rd_addr_q, OFF_RESULT)) begin
      rdata_d[RES_KIND_LSB +: 2] = last_kind_q;
      rdata_d[RES_FETCH_BIT] = last_fetch_q;
      rdata_d[RES_IDX_LSB +: SUB_W] = last_idx_q;
    end else if (hits(rd_addr_q, OFF_ABORTS)) begin
      rdata_d[15:0] = aborts_q;
    end
  end

  // data launched at the end of the wait state
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= '0;
    end else if (rd_pend_q) begin
      hrdata_o <= rdata_d;
    end
  end
endmodule

// File: test/sschk_checker.sv
// port checker for the substream check top
`timescale 1ns/100ps
module sschk_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic txn_valid_i,
  input wire logic txn_has_sub_i,
  input wire logic [sschk_pkg::SUB_W-1:0] txn_sub_idx_i,
  input wire logic [sschk_pkg::ADDR_W-1:0] txn_addr_i,
  input wire logic rsp_valid_o,
  input wire logic rsp_abort_o,
  input wire sschk_pkg::sschk_result_e rsp_kind_o,
  input wire logic [sschk_pkg::SUB_W-1:0] rsp_desc_idx_o,
  input wire logic rsp_fetch_desc_o
);
  import sschk_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_rsp_next: assert property (txn_valid_i |=> rsp_valid_o)
    else $error("no response one cycle after a transaction");
  a_rsp_idle: assert property (!txn_valid_i |=> !rsp_valid_o && !rsp_abort_o && rsp_kind_o == RES_ABORT)
    else $error("response without a transaction");
  a_abort_kind: assert property (rsp_valid_o |-> rsp_abort_o == (rsp_kind_o == RES_ABORT))
    else $error("abort flag and kind disagree");
  a_bypass_nofetch: assert property (rsp_kind_o inside {RES_PHYS, RES_INTER} |-> !rsp_fetch_desc_o)
    else $error("bypass fetched a descriptor");
  a_wide_addr: assert property (txn_valid_i && !txn_has_sub_i && txn_addr_i[63:48] != 16'h0000
    |=> !(rsp_kind_o inside {RES_PHYS, RES_INTER}))
    else $error("wide address bypassed");
  a_tag_index: assert property (txn_valid_i && txn_has_sub_i ##1 rsp_kind_o == RES_DESC
    |-> rsp_desc_idx_o == $past(txn_sub_idx_i) && rsp_fetch_desc_o)
    else $error("tagged descriptor index wrong");
  a_tag_nobypass: assert property (txn_valid_i && txn_has_sub_i |=> rsp_kind_o inside {RES_ABORT, RES_DESC})
    else $error("tagged transaction bypassed");
  a_untag_zero: assert property (txn_valid_i && !txn_has_sub_i ##1 rsp_kind_o == RES_DESC
    |-> rsp_desc_idx_o == 20'h00000)
    else $error("untagged descriptor index not zero");
  c_abort: cover property (rsp_valid_o && rsp_abort_o);
  c_desc: cover property (rsp_kind_o == RES_DESC);
  c_inter: cover property (rsp_kind_o == RES_INTER);
endmodule

bind sschk_top sschk_checker sschk_checker_i (.sys_clk_i, .nrst_i, .txn_valid_i, .txn_has_sub_i, .txn_sub_idx_i,
  .txn_addr_i, .rsp_valid_o, .rsp_abort_o, .rsp_kind_o, .rsp_desc_idx_o, .rsp_fetch_desc_o);

// File: test/sschk_client_model.sv
// client master issuing tagged and untagged transactions
`timescale 1ns/100ps
module sschk_client_model (
  input wire logic clk_i,
  output logic txn_valid_o,
  output logic txn_has_sub_o,
  output logic [sschk_pkg::SUB_W-1:0] txn_sub_idx_o,
  output logic [sschk_pkg::ADDR_W-1:0] txn_addr_o
);
  import sschk_pkg::*;
  initial begin
    txn_valid_o = 1'b0;
    txn_has_sub_o = 1'b0;
    txn_sub_idx_o = 20'h00000;
    txn_addr_o = 64'h0;
  end
  // fields inverted outside the valid cycle so stale values never pass
  task automatic issue(input logic h, input logic [SUB_W-1:0] i, input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    txn_valid_o <= 1'b1;
    txn_has_sub_o <= h;
    txn_sub_idx_o <= i;
    txn_addr_o <= a;
    @(posedge clk_i);
    txn_valid_o <= 1'b0;
    txn_has_sub_o <= ~h;
    txn_sub_idx_o <= ~i;
    txn_addr_o <= ~a;
  endtask
endmodule

// File: test/tb_sschk_top.sv
// self-checking bench for the substream check top
`timescale 1ns/100ps
module tb_sschk_top;
  import sschk_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, irq, tv, th, rv, ra, rf;
  logic [31:0] hrdata;
  logic [SUB_W-1:0] ti, ri;
  logic [ADDR_W-1:0] ta;
  sschk_result_e rk;
  int err_count = 0;
  int n_checks = 0;
  assign hready = hreadyout;
  always #50 clk = ~clk;
  sschk_client_model sschk_client_model_i (.clk_i(clk), .txn_valid_o(tv), .txn_has_sub_o(th),
    .txn_sub_idx_o(ti), .txn_addr_o(ta));
  sschk_top sschk_top_i (.sys_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .txn_valid_i(tv), .txn_has_sub_i(th), .txn_sub_idx_i(ti),
    .txn_addr_i(ta), .rsp_valid_o(rv), .rsp_abort_o(ra), .rsp_kind_o(rk), .rsp_desc_idx_o(ri),
    .rsp_fetch_desc_o(rf), .irq_o(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  function automatic logic [31:0] ent(input logic s1, input logic s2, input logic [1:0] d, input logic [4:0] c);
    return {11'h000, c, 6'h00, d, 6'h00, s2, s1};
  endfunction
  task automatic txn(input logic h, input logic [19:0] i, input logic [63:0] a, input sschk_result_e k,
                     input logic [19:0] ei);
    sschk_client_model_i.issue(h, i, a);
    #1;
    chk("rsp", {7'h00, rv, ra, rk, rf, ri}, {7'h00, 1'b1, k == RES_ABORT, k, k == RES_DESC, ei});
  endtask
  task automatic s_regs;
    rd("id", OFF_ID, {15'h0000, STAGE1_IMPL, 1'b0, INPUT_ADDRESS_WIDTH, 2'h0, SUPPORTED_SUBINDEX_WIDTH});
    rd("unmapped", 12'h018, 32'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b1, 2'h3, 5'h14));
    rd("entry", OFF_ENTRY, ent(1'b1, 1'b1, 2'h3, 5'h14));
  endtask
  task automatic s_s1off;
    wr(OFF_ENTRY, ent(1'b0, 1'b0, DSS_TERMINATE, 5'h05));
    txn(1'b0, 20'h0, 64'h1000, RES_PHYS, 20'h0);
    txn(1'b1, 20'h3, 64'h1000, RES_ABORT, 20'h0);
    wr(OFF_ENTRY, ent(1'b0, 1'b1, DSS_TERMINATE, 5'h05));
    txn(1'b0, 20'h0, 64'h2000, RES_INTER, 20'h0);
  endtask
  task automatic s_range;
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_TERMINATE, 5'h00));
    txn(1'b1, 20'h0, 64'h1000, RES_ABORT, 20'h0);
    txn(1'b0, 20'h0, 64'h1000, RES_DESC, 20'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_TERMINATE, 5'h04));
    txn(1'b1, 20'hf, 64'h1000, RES_DESC, 20'hf);
    rd("result", OFF_RESULT, 32'h00000f05);
    txn(1'b1, 20'h10, 64'h1000, RES_ABORT, 20'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_TERMINATE, 5'h14));
    txn(1'b1, 20'hfffff, 64'h1000, RES_DESC, 20'hfffff);
  endtask
  task automatic s_select;
    sschk_result_e ek[4] = '{RES_ABORT, RES_PHYS, RES_DESC, RES_ABORT};
    for (int d = 0; d < 4; d++) begin
      wr(OFF_ENTRY, ent(1'b1, 1'b0, d[1:0], 5'h04));
      txn(1'b0, 20'h0, 64'h1000, ek[d], 20'h0);
    end
    txn(1'b1, 20'h0, 64'h1000, RES_DESC, 20'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_BYPASS, 5'h04));
    txn(1'b0, 20'h0, 64'h0001000000000000, RES_ABORT, 20'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b1, DSS_BYPASS, 5'h04));
    txn(1'b0, 20'h0, 64'h0000fffffffffff0, RES_INTER, 20'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_SUBZERO, 5'h04));
    txn(1'b1, 20'h0, 64'h1000, RES_ABORT, 20'h0);
    txn(1'b1, 20'h1, 64'h1000, RES_DESC, 20'h1);
  endtask
  task automatic s_irq;
    wr(OFF_STATUS, 32'hf);
    wr(OFF_MASK, 32'h2);
    wr(OFF_ABORTS, 32'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_TERMINATE, 5'h04));
    txn(1'b0, 20'h0, 64'h1000, RES_ABORT, 20'h0);
    txn(1'b1, 20'h10, 64'h1000, RES_ABORT, 20'h0);
    rd("status", OFF_STATUS, 32'h3);
    rd("aborts", OFF_ABORTS, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(OFF_STATUS, 32'h2);
    rd("status", OFF_STATUS, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(OFF_ENTRY, ent(1'b1, 1'b0, DSS_TERMINATE, 5'h15));
    rd("status", OFF_STATUS, 32'h9);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    s_s1off();
    s_range();
    s_select();
    s_irq();
    end_sim();
  end
  // whole run is under two hundred cycles, so this only trips on a hang
  initial begin
    #500000;
    err_count++;
    end_sim();
  end
endmodule
